// ==== hw/nvm_erase_write_sequencer.sv ====
`timescale 1ns/1ps
module nvm_erase_write_sequencer
  import nvm_seq_pkg::*;
#(
  parameter int TW = 16,
  parameter int FL_CYC = FL_ERASE_CYC,
  parameter int EE_CYC = EE_OP_CYC,
  parameter int CH_CYC = CHIP_CYC,
  parameter int EA_CYC = EE_ALL_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpu_instr_done,
  input wire logic arr_ld,
  input wire logic arr_st,
  input wire logic arr_ee,
  input wire logic [23:0] arr_addr,
  input wire logic [7:0] arr_wdata,
  output logic cpu_halt,
  input wire logic dbg_cmd_wr,
  input wire logic [6:0] dbg_cmd,
  input wire logic eeprom_preserve_fuse,
  input wire logic device_locked,
  input wire logic bod_enable_fuse,
  input wire logic sleep_req,
  input wire logic sleep_idle,
  output logic op_start,
  output op_t op_kind,
  output logic [23:0] op_addr,
  output logic [4:0] op_bits,
  output logic [7:0] op_data,
  output logic op_incl_eeprom,
  output logic nvm_abort,
  output logic eeprom_ready_irq,
  output logic wake_req,
  output logic nvm_clk_keep,
  output logic nvm_sleep,
  output logic bod_hold
);
  // ****************************************
  // elaboration checks
  // ****************************************
  if (FL_CYC < 1 || EE_CYC < 1 || CH_CYC < 1 || EA_CYC < 1) begin : g_chk_lo
    $error("operation time below one cycle");
  end
  if (FL_CYC >= 2**TW || EE_CYC >= 2**TW || CH_CYC >= 2**TW || EA_CYC >= 2**TW) begin : g_chk_hi
    $error("operation time exceeds timer width");
  end

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic is_idle(input logic [6:0] c);
    is_idle = (c == CMD_NONE) || (c == CMD_NOP);
  endfunction

  function automatic logic [23:0] clear_low(input logic [23:0] a, input logic [4:0] n);
    clear_low = a & ~((24'h1 << n) - 24'h1);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic ack_reg;
  logic [31:0] rd_reg;
  logic [31:0] rd_mux;
  logic [6:0] cmd_reg;
  logic [6:0] cmd_next;
  logic [7:0] map_reg;
  logic [7:0] map_next;
  logic [2:0] err_reg;
  logic [2:0] err_next;
  logic inten_reg;
  logic flag_reg;
  logic flag_next;
  logic [2:0] pcnt_reg;
  logic [2:0] pcnt_next;
  logic [2:0] icnt_reg;
  logic [2:0] icnt_next;
  logic ee_all_reg;
  logic chip_reg;
  logic op_start_reg;
  op_t op_kind_reg;
  op_t op_kind_next;
  logic [23:0] op_addr_reg;
  logic [23:0] op_addr_next;
  logic [4:0] op_bits_reg;
  logic [4:0] op_bits_next;
  logic [7:0] op_data_reg;
  logic op_incl_reg;
  logic fl_busy;
  logic fl_done;
  logic ee_busy;
  logic ee_done;

  // ****************************************
  // wishbone decode
  // ****************************************
  wire wb_req = wb_cyc_i && wb_stb_i;
  wire wb_wr = wb_req && wb_we_i && ack_reg && wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire cmd_wr = wb_wr && (wb_adr_i == OFS_CMD);
  wire map_wr = wb_wr && (wb_adr_i == OFS_MAP);
  wire stat_wr = wb_wr && (wb_adr_i == OFS_STATUS);
  wire inten_wr = wb_wr && (wb_adr_i == OFS_INTEN);
  wire flag_wr = wb_wr && (wb_adr_i == OFS_INTFLAG);
  wire key_wr = wb_wr && (wb_adr_i == OFS_KEY);

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0;
    if (wb_adr_i == OFS_CMD) begin
      rd_mux[6:0] = cmd_reg;
    end else if (wb_adr_i == OFS_MAP) begin
      rd_mux[7:0] = map_reg;
    end else if (wb_adr_i == OFS_STATUS) begin
      rd_mux[ERR_LSB+2:ERR_LSB] = err_reg;
      rd_mux[EEPROM_BUSY_FLAG_BIT] = ee_busy;
      rd_mux[FLASH_BUSY_FLAG_BIT] = fl_busy;
    end else if (wb_adr_i == OFS_INTEN) begin
      rd_mux[0] = inten_reg;
    end else if (wb_adr_i == OFS_INTFLAG) begin
      rd_mux[0] = flag_reg;
    end
  end

  // ack one cycle after request, dropped the next cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0;
    end else begin
      ack_reg <= wb_req && !ack_reg;
      rd_reg <= rd_mux;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;

  // ****************************************
  // change protection
  // ****************************************
  wire prog_open = (pcnt_reg != 3'h0);
  wire io_open = (icnt_reg != 3'h0);
  assign pcnt_next = (key_wr && wd == KEY_PROG) ? UNLOCK_INSTR :
    ((prog_open && cpu_instr_done) ? pcnt_reg - 3'h1 : pcnt_reg);
  assign icnt_next = (key_wr && wd == KEY_IO) ? UNLOCK_INSTR :
    ((io_open && cpu_instr_done) ? icnt_reg - 3'h1 : icnt_reg);

  // ****************************************
  // command register
  // ****************************************
  wire [6:0] cmd_new = wd[6:0];
  wire busy_any = fl_busy || ee_busy;
  wire cmd_try = cmd_wr && prog_open;
  wire collide = cmd_try && !is_idle(cmd_reg) && !is_idle(cmd_new) && (cmd_new != cmd_reg);
  wire cmd_take = cmd_try && !collide && (cmd_new != CMD_CHIP);
  wire ee_all_go = cmd_take && (cmd_new == CMD_EE_ALL) && !busy_any;
  wire chip_go = dbg_cmd_wr && (dbg_cmd == CMD_CHIP) && !busy_any;
  assign cmd_next = cmd_take ? cmd_new : cmd_reg;
  assign err_next = collide ? ERR_COLLISION : (stat_wr ? ERR_NONE : err_reg);

  // map/protect: protected bits set-only, mapping field held by lock
  wire [7:0] map_prot = io_open ? (map_reg | (wd & MAP_PROT_MASK)) : map_reg;
  wire [7:0] map_fld = map_reg[MAP_LOCK_BIT] ? map_reg : ((map_reg & ~MAP_FIELD_MASK) | (wd & MAP_FIELD_MASK));
  assign map_next = map_wr ? ((map_prot & MAP_PROT_MASK) | (map_fld & MAP_FIELD_MASK)) : map_reg;

  // ****************************************
  // mode decode
  // ****************************************
  wire fl_mode = (cmd_reg >= CMD_FL_MPE_LO) && (cmd_reg <= CMD_FL_MPE_HI);
  wire ee_wr_mode = (cmd_reg == CMD_EE_WR);
  wire ee_erwr_mode = (cmd_reg == CMD_EE_ERWR);
  wire ee_er_mode = (cmd_reg >= CMD_EE_BE_LO) && (cmd_reg <= CMD_EE_BE_HI);
  wire ee_mode = ee_wr_mode || ee_erwr_mode || ee_er_mode;
  wire [6:0] fl_k = cmd_reg - CMD_FL_BASE;
  wire [6:0] ee_k = cmd_reg - CMD_EE_BE_LO;
  wire [4:0] fl_bits = FL_PAGE_LOG2 + {2'b00, fl_k[2:0]};
  wire [4:0] ee_bits = ee_er_mode ? {2'b00, ee_k[2:0]} : 5'h00;

  // ****************************************
  // array access and halting
  // ****************************************
  wire acc = arr_ld || arr_st;
  assign cpu_halt = fl_busy || ee_all_reg || (acc && ee_busy);
  wire st_go = arr_st && !cpu_halt;
  wire fl_go = st_go && !arr_ee && fl_mode;
  wire ee_go = st_go && arr_ee && ee_mode;

  // next operation descriptor
  always_comb begin
    op_kind_next = op_kind_reg;
    op_bits_next = op_bits_reg;
    op_addr_next = op_addr_reg;
    if (chip_go) begin
      op_kind_next = OP_CHIP;
      op_bits_next = 5'h00;
      op_addr_next = 24'h0;
    end else if (ee_all_go) begin
      op_kind_next = OP_EE_ALL;
      op_bits_next = 5'h00;
      op_addr_next = 24'h0;
    end else if (fl_go) begin
      op_kind_next = OP_FL_ERASE;
      op_bits_next = fl_bits;
      op_addr_next = clear_low(arr_addr, fl_bits);
    end else if (ee_go) begin
      op_kind_next = ee_wr_mode ? OP_EE_WRITE : (ee_erwr_mode ? OP_EE_ERWR : OP_EE_ERASE);
      op_bits_next = ee_bits;
      op_addr_next = clear_low(arr_addr, ee_bits);
    end
  end

  wire any_go = chip_go || ee_all_go || fl_go || ee_go;
  wire wr_data = ee_go && (ee_wr_mode || ee_erwr_mode);
  // chip erase ignores map/protect bits entirely
  wire incl_ee = !eeprom_preserve_fuse || device_locked;

  // ****************************************
  // busy timers
  // ****************************************
  wire fl_start = fl_go || chip_go;
  wire ee_start = ee_go || ee_all_go || (chip_go && incl_ee);
  wire [TW-1:0] fl_cyc = chip_go ? TW'(CH_CYC) : TW'(FL_CYC);
  wire [TW-1:0] ee_cyc = chip_go ? TW'(CH_CYC) : (ee_all_go ? TW'(EA_CYC) : TW'(EE_CYC));

  nvm_busy_timer #(.W(TW)) u_fl_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(fl_start),
    .cycles(fl_cyc),
    .busy(fl_busy),
    .done(fl_done)
  );

  nvm_busy_timer #(.W(TW)) u_ee_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(ee_start),
    .cycles(ee_cyc),
    .busy(ee_busy),
    .done(ee_done)
  );

  // ****************************************
  // interrupt flag
  // ****************************************
  assign flag_next = ee_done || (flag_reg && !(flag_wr && wd[0]));

  // ****************************************
  // register updates
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmd_reg <= CMD_NONE;
      map_reg <= MAP_RESET;
      err_reg <= ERR_NONE;
      inten_reg <= 1'b0;
      flag_reg <= 1'b0;
      pcnt_reg <= 3'h0;
      icnt_reg <= 3'h0;
    end else begin
      cmd_reg <= cmd_next;
      map_reg <= map_next;
      err_reg <= err_next;
      inten_reg <= inten_wr ? wd[0] : inten_reg;
      flag_reg <= flag_next;
      pcnt_reg <= pcnt_next;
      icnt_reg <= icnt_next;
    end
  end

  // operation run flags
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ee_all_reg <= 1'b0;
      chip_reg <= 1'b0;
    end else begin
      ee_all_reg <= ee_all_go || (ee_all_reg && !ee_done);
      chip_reg <= chip_go || (chip_reg && !fl_done);
    end
  end

  // operation descriptor to the array
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      op_start_reg <= 1'b0;
      op_kind_reg <= OP_IDLE;
      op_addr_reg <= 24'h0;
      op_bits_reg <= 5'h00;
      op_data_reg <= ERASED_BYTE;
      op_incl_reg <= 1'b0;
    end else begin
      op_start_reg <= any_go;
      op_kind_reg <= op_kind_next;
      op_addr_reg <= op_addr_next;
      op_bits_reg <= op_bits_next;
      op_data_reg <= any_go ? (wr_data ? arr_wdata : ERASED_BYTE) : op_data_reg;
      op_incl_reg <= chip_go ? incl_ee : (any_go ? 1'b0 : op_incl_reg);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign op_start = op_start_reg;
  assign op_kind = op_kind_reg;
  assign op_addr = op_addr_reg;
  assign op_bits = op_bits_reg;
  assign op_data = op_data_reg;
  assign op_incl_eeprom = op_incl_reg;
  assign nvm_abort = srst && busy_any;
  assign eeprom_ready_irq = flag_reg && inten_reg;
  assign wake_req = eeprom_ready_irq && sleep_req && sleep_idle;
  assign nvm_clk_keep = sleep_req && ee_busy;
  assign nvm_sleep = sleep_req && !ee_busy;
  assign bod_hold = chip_reg && bod_enable_fuse;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_fl_halt;
    fl_busy |-> cpu_halt;
  endproperty
  a_fl_halt: assert property (p_fl_halt) else $error("flash erase without halt");

  property p_ee_halt;
    (acc && ee_busy) |-> cpu_halt;
  endproperty
  a_ee_halt: assert property (p_ee_halt) else $error("access during eeprom busy not halted");

  property p_ee_run;
    (ee_busy && !ee_all_reg && !fl_busy && !acc) |-> !cpu_halt;
  endproperty
  a_ee_run: assert property (p_ee_run) else $error("cpu halted without access");

  property p_mask;
    op_start |-> (op_addr == clear_low(op_addr, op_bits));
  endproperty
  a_mask: assert property (p_mask) else $error("low address bits not cleared");

  property p_erase_ff;
    (op_start && op_kind == OP_EE_ERASE) |-> (op_data == ERASED_BYTE);
  endproperty
  a_erase_ff: assert property (p_erase_ff) else $error("byte erase data not ff");

  property p_chip_src;
    (op_start && op_kind == OP_CHIP) |-> $past(dbg_cmd_wr);
  endproperty
  a_chip_src: assert property (p_chip_src) else $error("chip erase not from debug port");

  property p_locked;
    (op_start && op_kind == OP_CHIP && $past(device_locked)) |-> op_incl_eeprom;
  endproperty
  a_locked: assert property (p_locked) else $error("locked chip erase skipped eeprom");

  property p_ready;
    ($fell(ee_busy) && !$past(srst)) |-> flag_reg;
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag not set");

  property p_irq_hold;
    (eeprom_ready_irq && !wb_wr && !srst) |=> eeprom_ready_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped while flag set");

  property p_nounlock;
    (cmd_wr && !prog_open) |=> $stable(cmd_reg);
  endproperty
  a_nounlock: assert property (p_nounlock) else $error("command changed without key");

  property p_unlock;
    (key_wr && wd == KEY_PROG) |=> (pcnt_reg == UNLOCK_INSTR);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock window not opened");

  property p_collide;
    collide |=> (err_reg == ERR_COLLISION) && $stable(cmd_reg);
  endproperty
  a_collide: assert property (p_collide) else $error("collision not flagged");

  property p_sleep;
    (sleep_req && ee_busy) |-> (nvm_clk_keep && !nvm_sleep);
  endproperty
  a_sleep: assert property (p_sleep) else $error("slept during eeprom operation");

  c_ee_write: cover property (op_start && op_kind == OP_EE_WRITE);
  c_fl_erase: cover property (op_start && op_kind == OP_FL_ERASE && op_bits == 5'h0E);
  c_chip: cover property (op_start && op_kind == OP_CHIP);
  c_irq: cover property (eeprom_ready_irq);
endmodule

// ==== shared/nvm_seq_pkg.sv ====
package nvm_seq_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam int ADR_W = 5;
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_MAP = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_INTEN = 5'h0C;
  localparam logic [4:0] OFS_INTFLAG = 5'h10;
  localparam logic [4:0] OFS_KEY = 5'h14;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [6:0] CMD_NONE = 7'h00;
  localparam logic [6:0] CMD_NOP = 7'h01;
  localparam logic [6:0] CMD_FL_BASE = 7'h08;
  localparam logic [6:0] CMD_FL_MPE_LO = 7'h09;
  localparam logic [6:0] CMD_FL_MPE_HI = 7'h0D;
  localparam logic [6:0] CMD_EE_WR = 7'h12;
  localparam logic [6:0] CMD_EE_ERWR = 7'h13;
  localparam logic [6:0] CMD_EE_BE_LO = 7'h18;
  localparam logic [6:0] CMD_EE_BE_HI = 7'h1D;
  localparam logic [6:0] CMD_CHIP = 7'h20;
  localparam logic [6:0] CMD_EE_ALL = 7'h30;
  // ****************************************
  // fields, keys, reset values
  // ****************************************
  localparam logic [7:0] MAP_RESET = 8'h30;
  localparam logic [7:0] MAP_PROT_MASK = 8'h87;
  localparam logic [7:0] MAP_FIELD_MASK = 8'h30;
  localparam int MAP_LOCK_BIT = 7;
  localparam int ERR_LSB = 4;
  localparam int EEPROM_BUSY_FLAG_BIT = 1;
  localparam int FLASH_BUSY_FLAG_BIT = 0;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_COLLISION = 3'h2;
  localparam logic [7:0] KEY_PROG = 8'hA5; // arbitrary value
  localparam logic [7:0] KEY_IO = 8'hC3; // arbitrary value
  localparam logic [2:0] UNLOCK_INSTR = 3'h4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [4:0] FL_PAGE_LOG2 = 5'h09;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_FL_ERASE_NS = 10000;
  localparam int T_EE_OP_NS = 4000;
  localparam int T_CHIP_NS = 20000;
  localparam int T_EE_ALL_NS = 20000;
  localparam int FL_ERASE_CYC = (T_FL_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_OP_CYC = (T_EE_OP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIP_CYC = (T_CHIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_ALL_CYC = (T_EE_ALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // operation kinds
  // ****************************************
  typedef enum logic [6:0] {
    OP_IDLE = 7'h01,
    OP_FL_ERASE = 7'h02,
    OP_EE_WRITE = 7'h04,
    OP_EE_ERASE = 7'h08,
    OP_EE_ERWR = 7'h10,
    OP_CHIP = 7'h20,
    OP_EE_ALL = 7'h40
  } op_t;
endpackage

// ==== hw/nvm_busy_timer.sv ====
`timescale 1ns/1ps
module nvm_busy_timer
  import nvm_seq_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [W-1:0] cycles,
  output logic busy,
  output logic done
);
  // ****************************************
  // elaboration check
  // ****************************************
  if (W < 2 || W > 24) begin : g_chk
    $error("timer width out of range");
  end

  logic busy_reg;
  logic busy_next;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // count down, last cycle flagged as done
  assign done = busy_reg && (cnt_reg == {{(W-1){1'b0}}, 1'b1});
  assign busy_next = start ? 1'b1 : (done ? 1'b0 : busy_reg);
  assign cnt_next = start ? cycles : (busy_reg ? cnt_reg - 1'b1 : cnt_reg);
  assign busy = busy_reg;

  // state flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ==== testbench/cpu_model.sv ====
`timescale 1ns/1ps
// ****************
// cpu core model: bus master, unlock, array loads and stores
// ****************
module cpu_model
  import nvm_seq_pkg::*;
(
  input wire logic sys_clk,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [4:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  output logic cpu_instr_done,
  output logic arr_ld,
  output logic arr_st,
  output logic arr_ee,
  output logic [23:0] arr_addr,
  output logic [7:0] arr_wdata,
  input wire logic cpu_halt
);
  int tmo = 0;
  int hw;
  logic [7:0] q;
  // idle levels at time zero
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, cpu_instr_done, arr_ld, arr_st} = '0;
    {arr_ee, arr_addr, arr_wdata} = '0;
  end
  // one classic cycle, held until ack; released data turns over
  task bus(input logic we, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, a, 4'h1};
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 64);
    q = wb_dat_o[7:0];
    tmo += int'(n >= 64);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    wb_dat_i <= ~wb_dat_i;
  endtask
  // retired instruction pulses
  task instr(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      cpu_instr_done <= 1'b1;
      @(posedge sys_clk);
      cpu_instr_done <= 1'b0;
    end
  endtask
  // wait for idle, unlock, write the command
  task cmd(input logic [6:0] c);
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_STATUS, 8'h00);
      n++;
    end while (q[1:0] !== 2'b00 && n < 300);
    tmo += int'(n >= 300);
    bus(1'b1, OFS_KEY, KEY_PROG);
    bus(1'b1, OFS_CMD, {1'b0, c});
  endtask
  // array access, held while halted; hw counts edges waited
  task acc(input logic ld, input logic ee, input logic [23:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {arr_ld, arr_st, arr_ee, arr_addr, arr_wdata} <= {ld, !ld, ee, a, d};
    hw = 0;
    do begin
      @(posedge sys_clk);
      hw++;
    end while (cpu_halt !== 1'b0 && hw < 999);
    tmo += int'(hw >= 999);
    {arr_ld, arr_st} <= 2'b00;
    {arr_addr, arr_wdata} <= ~{arr_addr, arr_wdata};
  endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb
  import nvm_seq_pkg::*;
;
  typedef struct {op_t k; logic [23:0] a; logic [4:0] b; logic [7:0] d; logic f;} note_t;
  logic sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_instr_done, arr_ld, arr_st, arr_ee;
  logic [4:0] wb_adr_i, op_bits;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [23:0] arr_addr, op_addr, a;
  logic [7:0] arr_wdata, op_data, d;
  logic cpu_halt, dbg_cmd_wr, eeprom_preserve_fuse, device_locked, bod_enable_fuse, sleep_req, sleep_idle;
  logic [6:0] dbg_cmd;
  logic op_start, op_incl_eeprom, nvm_abort, eeprom_ready_irq, wake_req, nvm_clk_keep, nvm_sleep, bod_hold;
  op_t op_kind;
  note_t notes[$];
  note_t nt;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  nvm_erase_write_sequencer #(.FL_CYC(6), .EE_CYC(5), .CH_CYC(8), .EA_CYC(8)) DUT (
    .sys_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .cpu_instr_done, .arr_ld, .arr_st, .arr_ee, .arr_addr, .arr_wdata, .cpu_halt, .dbg_cmd_wr, .dbg_cmd,
    .eeprom_preserve_fuse, .device_locked, .bod_enable_fuse, .sleep_req, .sleep_idle, .op_start, .op_kind,
    .op_addr, .op_bits, .op_data, .op_incl_eeprom, .nvm_abort, .eeprom_ready_irq, .wake_req, .nvm_clk_keep,
    .nvm_sleep, .bod_hold);
  cpu_model cpu (.sys_clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .cpu_instr_done, .arr_ld, .arr_st, .arr_ee, .arr_addr, .arr_wdata, .cpu_halt);
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ****************
  // helpers
  // ****************
  task chk(input logic [63:0] g, input logic [63:0] e, input string m);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task ex(input op_t k, input logic [23:0] ea, input logic [4:0] b, input logic [7:0] ed, input logic f);
    notes.push_back('{k, ea, b, ed, f});
  endtask
  task go(input logic [6:0] c);
    cpu.cmd(CMD_NONE);
    cpu.cmd(c);
  endtask
  task settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // result watcher takes the oldest note per started operation, mid-cycle
  always @(negedge sys_clk) begin
    if (op_start === 1'b1) begin
      if (notes.size() == 0) chk(64'd1, 64'd0, "unexpected op");
      else begin
        nt = notes.pop_front();
        chk(op_kind, nt.k, "op kind");
        if (nt.f) chk({op_addr, op_bits, op_data}, {nt.a, nt.b, nt.d}, "op fields");
      end
    end
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cpu.tmo != 0 || cyc > 90000) begin
      failures++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    {srst, dbg_cmd_wr, dbg_cmd, eeprom_preserve_fuse, device_locked, bod_enable_fuse, sleep_req, sleep_idle} = 14'h2004;
    void'($urandom(32'hBEBB));
    a = $urandom & 24'h1FF;
    d = $urandom;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    cpu.bus(1'b0, OFS_MAP, 8'h00);
    chk(cpu.q, MAP_RESET, "map reset");
    cpu.bus(1'b1, OFS_CMD, CMD_EE_WR);
    cpu.bus(1'b1, OFS_KEY, KEY_PROG);
    cpu.instr(5);
    cpu.bus(1'b1, OFS_CMD, CMD_EE_WR);
    cpu.bus(1'b0, OFS_CMD, 8'h00);
    chk(cpu.q, CMD_NONE, "locked write");
    $display("test protect done");
    for (int k = 0; k < 6; k++) begin
      go(7'(CMD_EE_BE_LO + k));
      ex(OP_EE_ERASE, a & ~((24'h1 << k) - 24'h1), 5'(k), ERASED_BYTE, 1'b1);
      cpu.acc(1'b0, 1'b1, a, 8'($urandom));
    end
    go(CMD_EE_ERWR);
    ex(OP_EE_ERWR, a, 5'h0, d, 1'b1);
    cpu.acc(1'b0, 1'b1, a, d);
    go(CMD_EE_WR);
    ex(OP_EE_WRITE, a ^ 24'h1, 5'h0, d, 1'b1);
    cpu.acc(1'b0, 1'b1, a ^ 24'h1, d);
    ex(OP_EE_WRITE, a ^ 24'h2, 5'h0, ~d, 1'b1);
    cpu.acc(1'b0, 1'b1, a ^ 24'h2, ~d);
    chk(cpu.hw > 1, 1'b1, "store wait");
    cpu.acc(1'b1, 1'b1, a, 8'h00);
    chk(cpu.hw > 1, 1'b1, "load wait");
    cpu.cmd(CMD_EE_ERWR);
    cpu.bus(1'b0, OFS_STATUS, 8'h00);
    chk(cpu.q[6:4], ERR_COLLISION, "collision");
    cpu.bus(1'b0, OFS_CMD, 8'h00);
    chk(cpu.q, CMD_EE_WR, "cmd kept");
    cpu.bus(1'b1, OFS_STATUS, 8'h00);
    $display("test eeprom done");
    for (int k = 1; k < 6; k++) begin
      go(7'(CMD_FL_BASE + k));
      a = $urandom;
      ex(OP_FL_ERASE, a & ~((24'h1 << (FL_PAGE_LOG2 + k)) - 24'h1), 5'(FL_PAGE_LOG2 + k), ERASED_BYTE, 1'b1);
      cpu.acc(1'b0, 1'b0, a, 8'($urandom));
    end
    $display("test flash done");
    go(CMD_EE_ERWR);
    cpu.bus(1'b1, OFS_INTFLAG, 8'h01);
    cpu.bus(1'b1, OFS_INTEN, 8'h01);
    {sleep_req, sleep_idle} <= 2'b11;
    ex(OP_EE_ERWR, 24'h3, 5'h0, d, 1'b1);
    cpu.acc(1'b0, 1'b1, 24'h3, d);
    settle(2);
    chk({nvm_clk_keep, nvm_sleep, eeprom_ready_irq}, 3'b100, "sleep held");
    for (int n = 0; n < 99 && eeprom_ready_irq !== 1'b1; n++) settle(1);
    chk({nvm_sleep, wake_req, eeprom_ready_irq}, 3'b111, "ready wake");
    @(posedge sys_clk);
    sleep_idle <= 1'b0;
    settle(1);
    chk(wake_req, 1'b0, "deep sleep");
    cpu.bus(1'b1, OFS_INTFLAG, 8'h00);
    chk(eeprom_ready_irq, 1'b1, "zero keeps");
    cpu.bus(1'b1, OFS_INTFLAG, 8'h01);
    settle(1);
    chk(eeprom_ready_irq, 1'b0, "one clears");
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    go(CMD_EE_ALL);
    ex(OP_EE_ALL, 24'h0, 5'h0, 8'h0, 1'b0);
    settle(3);
    chk(cpu_halt, 1'b1, "erase halt");
    go(CMD_CHIP);
    cpu.bus(1'b0, OFS_CMD, 8'h00);
    chk(cpu.q == CMD_CHIP, 1'b0, "cpu chip cmd");
    cpu.bus(1'b1, OFS_KEY, KEY_IO);
    cpu.bus(1'b1, OFS_MAP, 8'h07);
    for (int i = 0; i < 3; i++) begin
      {eeprom_preserve_fuse, device_locked} <= 2'(i + (i > 0));
      cpu.cmd(CMD_NONE);
      ex(OP_CHIP, 24'h0, 5'h0, 8'h0, 1'b0);
      {dbg_cmd_wr, dbg_cmd} <= {1'b1, CMD_CHIP};
      @(posedge sys_clk);
      dbg_cmd_wr <= 1'b0;
      settle(3);
      chk({op_incl_eeprom, bod_hold}, {device_locked | !eeprom_preserve_fuse, 1'b1}, "chip");
    end
    $display("test chip done");
    go(CMD_EE_WR);
    ex(OP_EE_WRITE, 24'h4, 5'h0, d, 1'b1);
    cpu.acc(1'b0, 1'b1, 24'h4, d);
    @(posedge sys_clk);
    srst <= 1'b1;
    #1;
    chk(nvm_abort, 1'b1, "abort");
    @(posedge sys_clk);
    srst <= 1'b0;
    settle(1);
    chk({cpu_halt, op_kind}, {1'b0, OP_IDLE}, "after abort");
    chk(notes.size(), 64'd0, "missing op");
    $display("test abort done");
    close_out();
  end
endmodule
